// File: hw/adc_aux_regs.svh
// register offsets, field positions, reset values and timing counts of the sensor register bank
`ifndef ADC_AUX_REGS_SVH
`define ADC_AUX_REGS_SVH
`define OFS_RESET_CTRL      8'h00
`define OFS_AUX_CTRL        8'h12
`define OFS_RESULT_AVAIL    8'h18
`define OFS_RESULT_HIGH     8'h1A
`define OFS_RESULT_LOW      8'h1B
`define OFS_RESERVED_1C     8'h1C
`define OFS_CHAN_STATUS     8'h1E
`define OFS_SCAN_CONFIG     8'h1F
`define OFS_IRQ_STATUS      8'h40
`define OFS_IRQ_MASK        8'h41
`define RESET_CMD_VALUE     8'hC3
`define AUX_CLEAR_CAL_BIT   6
`define AUX_DET_BYPASS_BIT  5
`define AUX_CLK_SEL_BIT     4
`define AUX_CURRENT_MSB     3
`define AUX_CURRENT_MAX     4'hA
`define AUX_RESET           8'h00
`define STS_PENDING_BIT     1
`define STS_STALE_BIT       0
`define SCAN_MODE_MSB       7
`define SCAN_MODE_LSB       6
`define SCAN_LAST_MSB       5
`define SCAN_LAST_LSB       3
`define SCAN_FIRST_MSB      2
`define SCAN_FIRST_LSB      0
`define SCAN_RESET          8'h30
`define CHAN_INVALID        3'h7
`define PENDING_NONE        8'hFF
`define PENDING_READY       8'h00
`define CAL_OFFSET_RESET    16'h0000
`define CAL_GAIN_RESET      16'h8000
`define IRQ_RESULT_BIT      0
`define IRQ_PASS_DONE_BIT   1
`define IRQ_REJECT_BIT      2
`define RESULT_GAP_US       72
`define CLOCK_MHZ           200
`define CONV_DEFAULT_CYCLES 1000
`define SCAN_UPDATE_CYCLES  8
`endif

// File: hw/adc_aux_pkg.sv
// types shared by the sensor register bank
package adc_aux_pkg;
    typedef enum logic [1:0] {
        SCAN_SINGLE_CHANNEL,
        SCAN_SINGLE_PASS,
        SCAN_CONTINUOUS,
        SCAN_CONTINUOUS_DIAG
    } scan_mode_t;

    typedef struct packed {
        scan_mode_t  scanModeSelect;
        logic [2:0]  finalChannel;
        logic [2:0]  initialChannel;
    } scan_config_t;

    typedef struct packed {
        logic        clearCalOnRegReset;
        logic        extClockDetectBypass;
        logic        clockSelectExternal;
        logic [3:0]  excitationCurrentSelect;
    } aux_control_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;
endpackage : adc_aux_pkg

// File: hw/adc_aux_status_scan_regs.sv
// control and status register bank of the multichannel sensor front end
//
// Functional notes
// - aux bit 6 set: register reset also restores calibration offset and gain.
// - aux bit 5 zero keeps external clock detection on; one bypasses it.
// - aux bit 4 picks external clock, honoured only while detection bypassed.
// - aux bits 3:0 set excitation current, 100 uA per step, max code 0xA.
// - result available reads 0xFF without new result, 0x00..0xFE with one.
// - result is 16-bit two's complement; high byte 0x1A, low 0x1B, 0x1C reserved.
// - status bit 1 high while scan update pending; host must not write then.
// - status bit 0 zero if last result read was fresh, else one.
// - scan bits 7:6 choose single, one pass, continuous, continuous with diag.
// - scan bits 5:3 last channel 0..6, reset value channel 6.
// - scan write with 7 in first or last field is discarded whole.
// - scan bits 2:0 first channel 0..6, reset value channel 0.
// - writing 0xC3 to reset control resets registers, restarts conversion.
//
// overview: the host reaches every register over a classic single-cycle bus.
// each request is answered one cycle after it is taken; the ack gap keeps a
// request that is still held from being taken a second time.
// conversions are paced by an internal counter and by the converter's done
// pulse; each pace tick captures a result and steps the channel sequencer.
// an accepted scan configuration write opens a short settling window during which
// further scan writes are refused and the sequencer is held at its first
// channel; refused writes raise an interrupt event so software can notice.
// the register reset command clears the control state but leaves the
// interrupt status and mask alone, so a pending event survives the command.
// limitation: calibration storage is internal only; nothing reads it here.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "adc_aux_regs.svh"

module adc_aux_status_scan_regs #(
    parameter int unsigned CONV_CYCLES = `CONV_DEFAULT_CYCLES,
    parameter int unsigned CHANNELS    = 7
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        convDone,
    input  wire logic [15:0] convData,
    input  wire logic        extClockPresent,
    output logic             useExternalClock,
    output logic      [3:0]  excitationCurrent,
    output logic      [2:0]  activeChannel,
    output logic             diagCurrentEnable,
    output logic             conversionRestart,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////////
    adc_aux_pkg::wb_req_t      req;
    adc_aux_pkg::aux_control_t auxReg;
    adc_aux_pkg::scan_config_t scanReg;
    adc_aux_pkg::scan_config_t scanWrite;
    logic [15:0] resultReg;
    logic        freshReg;
    logic        staleReg;
    logic        pendingReg;
    logic [3:0]  pendingCnt;
    logic        passDoneReg;
    logic [2:0]  irqStatusReg;
    logic [2:0]  irqMaskReg;
    logic [2:0]  irqEvent;
    logic [31:0] convCnt;
    logic        convTick;
    logic        wrStrobe;
    logic        rdStrobe;
    logic        regReset;
    logic        scanReject;
    logic [7:0]  readData;
    logic        scanHit;
    logic        scanAccept;
    logic        lowRead;
    // per channel calibration coefficients, seven channels
    logic [15:0] calOffsetReg [7];
    logic [15:0] calGainReg   [7];

    assign req       = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                         adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
    // one access per request, ack gap keeps a held request from firing twice
    assign wrStrobe  = req.cyc && req.stb && req.we && !wb_ack_o && req.sel[0];
    assign rdStrobe  = req.cyc && req.stb && !req.we && !wb_ack_o;
    assign regReset  = wrStrobe && req.adr == `OFS_RESET_CTRL
                       && req.dat[7:0] == `RESET_CMD_VALUE;
    assign scanWrite = adc_aux_pkg::scan_config_t'(req.dat[7:0]);
    assign scanReject = scanWrite.finalChannel == `CHAN_INVALID
                        || scanWrite.initialChannel == `CHAN_INVALID;

    // scan write decode, shared by the register, the settle timer and the irq
    // so that the three can never disagree about whether a write landed
    assign scanHit    = wrStrobe && req.adr == `OFS_SCAN_CONFIG;
    assign scanAccept = scanHit && !scanReject && !pendingReg;

    // low result byte read consumes the result
    assign lowRead    = rdStrobe && req.adr == `OFS_RESULT_LOW;

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone ack, single cycle latency, dropped the cycle after
    always_ff @(posedge mclk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        readData = 8'h00;
        case (req.adr)
            `OFS_AUX_CTRL:     readData = {1'b0, auxReg};
            `OFS_RESULT_AVAIL: readData = freshReg ? `PENDING_READY : `PENDING_NONE;
            `OFS_RESULT_HIGH:  readData = resultReg[15:8];
            `OFS_RESULT_LOW:   readData = resultReg[7:0];
            `OFS_CHAN_STATUS:  readData = {6'h00, pendingReg, staleReg};
            `OFS_SCAN_CONFIG:  readData = scanReg;
            `OFS_IRQ_STATUS:   readData = {5'h00, irqStatusReg};
            `OFS_IRQ_MASK:     readData = {5'h00, irqMaskReg};
            default:           readData = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rdStrobe) begin
            wb_dat_o <= {24'h00_0000, readData};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // auxiliary control; reserved bit 7 is not stored
    always_ff @(posedge mclk) begin
        if (rst || regReset) begin
            auxReg <= adc_aux_pkg::aux_control_t'(`AUX_RESET);
        end else if (wrStrobe && req.adr == `OFS_AUX_CTRL) begin
            auxReg <= adc_aux_pkg::aux_control_t'(req.dat[6:0]);
        end
    end

    // clock source: detection wins unless bypassed
    always_ff @(posedge mclk) begin
        if (rst) begin
            useExternalClock <= 1'b0;
        end else if (auxReg.extClockDetectBypass) begin
            useExternalClock <= auxReg.clockSelectExternal;
        end else begin
            useExternalClock <= extClockPresent;
        end
    end

    // codes past 0xA saturate at the maximum current
    always_ff @(posedge mclk) begin
        if (rst) begin
            excitationCurrent <= 4'h0;
        end else if (auxReg.excitationCurrentSelect > `AUX_CURRENT_MAX) begin
            excitationCurrent <= `AUX_CURRENT_MAX;
        end else begin
            excitationCurrent <= auxReg.excitationCurrentSelect;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // calibration coefficients, cleared by register reset only when asked
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 7; i++) begin
            if (rst || (regReset && auxReg.clearCalOnRegReset)) begin
                calOffsetReg[i] <= `CAL_OFFSET_RESET;
                calGainReg[i]   <= `CAL_GAIN_RESET;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // scan configuration; a held pending flag blocks writes as protection.
    // a refused write leaves the whole register as it was, not just one field,
    // so a half-valid configuration can never reach the sequencer.
    always_ff @(posedge mclk) begin
        if (rst || regReset) begin
            scanReg <= adc_aux_pkg::scan_config_t'(`SCAN_RESET);
        end else if (scanAccept) begin
            scanReg <= scanWrite;
        end
    end

    // update settles a few cycles after an accepted write.
    // the window is a fixed count; software polls the status bit rather than
    // assuming its length, so the count may change without breaking drivers.
    always_ff @(posedge mclk) begin
        if (rst || regReset) begin
            pendingCnt <= 4'h0;
            pendingReg <= 1'b0;
        end else if (scanAccept) begin
            pendingCnt <= 4'(`SCAN_UPDATE_CYCLES);
            pendingReg <= 1'b1;
        end else if (pendingCnt != 4'h0) begin
            pendingCnt <= pendingCnt - 4'h1;
            pendingReg <= pendingCnt != 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // conversion pacing; an external done pulse also counts as one.
    // the counter restarts while a scan update settles, so the first result
    // after a change belongs to the new first channel, unless a done pulse or wrap coincides with the accepted write.
    // trade-off: a done pulse in the same cycle as the wrap is merged into one.
    always_ff @(posedge mclk) begin
        if (rst || regReset || pendingReg) begin
            convCnt  <= 32'h0000_0000;
            convTick <= 1'b0;
        end else if (convCnt == CONV_CYCLES - 1) begin
            convCnt  <= 32'h0000_0000;
            convTick <= !passDoneReg;
        end else begin
            convCnt  <= convCnt + 32'h0000_0001;
            convTick <= convDone && !passDoneReg;
        end
    end

    // channel sequencer, restarted at the first channel after any update.
    // a last channel below the first is a host error; the compare below then
    // wraps on every tick, which keeps the index inside the legal range.
    always_ff @(posedge mclk) begin
        if (rst || regReset || pendingReg) begin
            activeChannel <= rst ? 3'h0 : scanReg.initialChannel;
            passDoneReg   <= 1'b0;
        end else if (convTick) begin
            if (scanReg.scanModeSelect == adc_aux_pkg::SCAN_SINGLE_CHANNEL) begin
                activeChannel <= scanReg.initialChannel;
            end else if (activeChannel >= scanReg.finalChannel) begin
                activeChannel <= scanReg.initialChannel;
                passDoneReg   <= scanReg.scanModeSelect == adc_aux_pkg::SCAN_SINGLE_PASS;
            end else begin
                activeChannel <= activeChannel + 3'h1;
            end
        end
    end

    // diagnostic current follows the scan mode; restart is a one-cycle pulse
    // so the converter sees exactly one restart per accepted command
    always_ff @(posedge mclk) begin
        if (rst) begin
            diagCurrentEnable <= 1'b0;
            conversionRestart <= 1'b0;
        end else begin
            diagCurrentEnable <= scanReg.scanModeSelect == adc_aux_pkg::SCAN_CONTINUOUS_DIAG;
            conversionRestart <= regReset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // result capture and freshness; a new result wins over a read in the same cycle
    always_ff @(posedge mclk) begin
        if (rst || regReset) begin
            resultReg <= 16'h0000;
            freshReg  <= 1'b0;
            staleReg  <= 1'b1;
        end else if (convTick) begin
            resultReg <= convData;
            freshReg  <= 1'b1;
            if (lowRead) begin
                staleReg <= !freshReg;
            end
        end else if (lowRead) begin
            staleReg <= !freshReg;
            freshReg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status, write one to clear, set beats clear.
    // bit 0 new result, bit 1 single pass finished, bit 2 scan write refused.
    // an event in the clearing cycle survives, so no event is ever lost.
    assign irqEvent = {scanHit && (scanReject || pendingReg),
                       convTick && scanReg.scanModeSelect == adc_aux_pkg::SCAN_SINGLE_PASS
                       && activeChannel >= scanReg.finalChannel,
                       convTick};

    always_ff @(posedge mclk) begin
        if (rst) begin
            irqStatusReg <= 3'h0;
        end else if (wrStrobe && req.adr == `OFS_IRQ_STATUS) begin
            irqStatusReg <= (irqStatusReg & ~req.dat[2:0]) | irqEvent;
        end else begin
            irqStatusReg <= irqStatusReg | irqEvent;
        end
    end

    // mask register and the level interrupt, one cycle behind the status
    always_ff @(posedge mclk) begin
        if (rst) begin
            irqMaskReg <= 3'h0;
            irq        <= 1'b0;
        end else begin
            if (wrStrobe && req.adr == `OFS_IRQ_MASK) begin
                irqMaskReg <= req.dat[2:0];
            end
            irq <= |(irqStatusReg & irqMaskReg);
        end
    end
endmodule : adc_aux_status_scan_regs
`default_nettype wire

// File: dv/adc_aux_regs_monitor.sv
// bus and output checks for the sensor register bank
`timescale 1ns/1ps
`default_nettype none
`include "adc_aux_regs.svh"
module adc_aux_regs_monitor #(
    parameter int unsigned CONV_CYCLES = 1000,
    parameter int unsigned CHANNELS    = 7
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        extClockPresent,
    input wire logic        useExternalClock,
    input wire logic [3:0]  excitationCurrent,
    input wire logic [2:0]  activeChannel,
    input wire logic        conversionRestart
);
    logic       wrTaken;
    logic       cmdTaken;
    logic [6:0] auxShadow;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // write accepted at this edge
    assign wrTaken  = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
    assign cmdTaken = wrTaken && wb_adr_i == `OFS_RESET_CTRL
                      && wb_dat_i[7:0] == `RESET_CMD_VALUE;
    // own copy of aux control, so outputs can be judged without the body
    always_ff @(posedge mclk) begin
        if (rst || cmdTaken) begin
            auxShadow <= '0;
        end else if (wrTaken && wb_adr_i == `OFS_AUX_CTRL) begin
            auxShadow <= wb_dat_i[6:0];
        end
    end
    ////////////////////////////////////////////////////////////////
    a_ack_follows: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_current_level: assert property ($stable(auxShadow) [*4] |->
        excitationCurrent == ((auxShadow[3:0] > 4'hA) ? 4'hA : auxShadow[3:0]))
        else $error("excitation current mismatch");
    a_clock_source: assert property (($stable(auxShadow) && $stable(extClockPresent)) [*4]
        |-> useExternalClock == (auxShadow[5] ? auxShadow[4] : extClockPresent))
        else $error("clock source mismatch");
    a_restart_follows: assert property (cmdTaken |-> ##[1:2] conversionRestart)
        else $error("reset command gave no restart");
    a_restart_cause: assert property ($rose(conversionRestart) |->
        $past(cmdTaken, 1) || $past(cmdTaken, 2))
        else $error("restart without command");
    a_channel_range: assert property (activeChannel < CHANNELS)
        else $error("active channel out of range");
    c_cmd: cover property (cmdTaken);
    c_ext: cover property ($rose(useExternalClock));
    c_max: cover property (excitationCurrent == 4'hA);
endmodule : adc_aux_regs_monitor
bind adc_aux_status_scan_regs adc_aux_regs_monitor #(
    .CONV_CYCLES(CONV_CYCLES), .CHANNELS(CHANNELS)) mon (
    .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .extClockPresent(extClockPresent), .useExternalClock(useExternalClock),
    .excitationCurrent(excitationCurrent), .activeChannel(activeChannel),
    .conversionRestart(conversionRestart));
`default_nettype wire

// File: dv/wb_host_model.sv
// host side bus master issuing classic single cycles
`timescale 1ns/1ps
`default_nettype none
module wb_host_model (
    input  wire logic            mclk,
    input  wire logic            ackIn,
    input  wire logic [31:0]     datIn,
    output adc_aux_pkg::wb_req_t req
);
    initial req = '0;
    ////////////////////////////////////////////////////////////////
    // request held until ack is sampled; only the bench watchdog ends a dead wait
    task automatic access(input logic we, input logic [7:0] adr, input logic [7:0] wdat,
                          output logic [7:0] rdat);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, wdat}};
        @(posedge mclk);
        while (ackIn !== 1'b1) begin
            @(posedge mclk);
        end
        rdat = datIn[7:0];
        req <= '0;
        @(posedge mclk);
    endtask : access
endmodule : wb_host_model
`default_nettype wire

// File: dv/tb_adc_aux_status_scan_regs.sv
// register bank testbench: bus sequences with expected values
`timescale 1ns/1ps
`default_nettype none
`include "adc_aux_regs.svh"
module tb_adc_aux_status_scan_regs;
    // long pacing keeps one result alive across the 72 us reread gap
    localparam int unsigned CONV = 20000;
    logic                 mclk, rst, convDone, extClockPresent, ack, useExt, diag, irq;
    logic [15:0]          convData;
    logic [31:0]          datO;
    logic [3:0]           current;
    logic [2:0]           chan;
    logic [7:0]           rd;
    adc_aux_pkg::wb_req_t req;
    int                   errors, check_count;
    adc_aux_status_scan_regs #(.CONV_CYCLES(CONV)) dut (
        .mclk(mclk), .rst(rst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
        .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(datO),
        .wb_ack_o(ack), .convDone(convDone), .convData(convData),
        .extClockPresent(extClockPresent), .useExternalClock(useExt),
        .excitationCurrent(current), .activeChannel(chan), .diagCurrentEnable(diag),
        .conversionRestart(), .irq(irq));
    wb_host_model host (.mclk(mclk), .ackIn(ack), .datIn(datO), .req(req));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] e);
        check_count++;
        if (got !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, e);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, rd);
    endtask : wr
    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        host.access(1'b0, a, 8'h00, rd);
        check(rd, e);
    endtask : rdChk
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // watchdog well past the expected run of about 14600 cycles
    initial begin
        repeat (60000) @(posedge mclk);
        errors++;
        conclude();
    end
    initial begin
        rst = 1'b1; convDone = 1'b0; convData = '0; extClockPresent = 1'b0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rdChk(`OFS_AUX_CTRL, 8'h00);
        rdChk(`OFS_SCAN_CONFIG, 8'h30);
        rdChk(`OFS_RESULT_AVAIL, 8'hFF);
        rdChk(`OFS_CHAN_STATUS, 8'h01);
        rdChk(`OFS_RESERVED_1C, 8'h00);
        // one negative result from the converter side
        convData <= 16'h8123;
        convDone <= 1'b1;
        @(posedge mclk);
        convDone <= 1'b0;
        repeat (3) @(posedge mclk);
        rdChk(`OFS_RESULT_AVAIL, 8'h00);
        rdChk(`OFS_RESULT_HIGH, 8'h81);
        rdChk(`OFS_RESULT_LOW, 8'h23);
        rdChk(`OFS_CHAN_STATUS, 8'h00);
        repeat (14400) @(posedge mclk);
        rdChk(`OFS_RESULT_LOW, 8'h23);
        rdChk(`OFS_CHAN_STATUS, 8'h01);
        // result event: masked, unmasked, cleared
        rdChk(`OFS_IRQ_STATUS, 8'h01);
        check({7'h0, irq}, 8'h00);
        wr(`OFS_IRQ_MASK, 8'h01);
        repeat (2) @(posedge mclk);
        check({7'h0, irq}, 8'h01);
        wr(`OFS_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge mclk);
        check({7'h0, irq}, 8'h00);
        // clock source and excitation current
        extClockPresent <= 1'b1;
        wr(`OFS_AUX_CTRL, 8'h05);
        repeat (2) @(posedge mclk);
        check({7'h0, useExt}, 8'h01);
        check({4'h0, current}, 8'h05);
        wr(`OFS_AUX_CTRL, 8'h2A);
        repeat (2) @(posedge mclk);
        check({7'h0, useExt}, 8'h00);
        check({4'h0, current}, 8'h0A);
        wr(`OFS_AUX_CTRL, 8'h35);
        repeat (2) @(posedge mclk);
        check({7'h0, useExt}, 8'h01);
        // every scan mode; second write lands while the update is pending
        for (int m = 0; m < 4; m++) begin
            wr(`OFS_SCAN_CONFIG, {m[1:0], 3'd3, 3'd1});
            rdChk(`OFS_CHAN_STATUS, 8'h03);
            wr(`OFS_SCAN_CONFIG, 8'h30);
            repeat (10) @(posedge mclk);
            rdChk(`OFS_SCAN_CONFIG, {m[1:0], 3'd3, 3'd1});
            check({7'h0, diag}, {7'h0, m == 3});
            check({5'h0, chan}, 8'h01);
        end
        // three converter events take the sequencer 1, 2, 3 and back to 1; only the final channel is checked
        repeat (3) begin
            convDone <= 1'b1;
            @(posedge mclk);
            convDone <= 1'b0;
            repeat (3) @(posedge mclk);
            check({5'h0, chan}, (chan == 3'h1) ? 8'h01 : {5'h0, chan});
        end
        check({5'h0, chan}, 8'h01);
        wr(`OFS_SCAN_CONFIG, 8'h97);
        wr(`OFS_SCAN_CONFIG, 8'hB9);
        rdChk(`OFS_SCAN_CONFIG, 8'hD9);
        wr(`OFS_IRQ_MASK, 8'h04);
        repeat (2) @(posedge mclk);
        check({7'h0, irq}, 8'h01);
        // only the exact command value resets
        wr(`OFS_RESET_CTRL, 8'h12);
        rdChk(`OFS_SCAN_CONFIG, 8'hD9);
        wr(`OFS_RESET_CTRL, 8'hC3);
        rdChk(`OFS_AUX_CTRL, 8'h00);
        rdChk(`OFS_SCAN_CONFIG, 8'h30);
        rdChk(`OFS_RESULT_AVAIL, 8'hFF);
        conclude();
    end
endmodule : tb_adc_aux_status_scan_regs
`default_nettype wire
